// file: verilog/sarc_regs.svh
/*
  Register indices, reset values and field positions of the sideband
  accessory resistor classifier.
  Assumes: byte address on the bus is four times the index.
*/
`ifndef SARC_REGS_SVH
`define SARC_REGS_SVH

// ==========================================================
// Register indices
`define SARC_IDX_SLOT2_VHIGH  8'h34
`define SARC_IDX_SLOT2_VLOW   8'h35
`define SARC_IDX_SLOT2_CUR    8'h36
`define SARC_IDX_SLOT3_VHIGH  8'h37
`define SARC_IDX_SLOT3_VLOW   8'h38
`define SARC_IDX_SLOT3_CUR    8'h39
`define SARC_IDX_SLOT4_VLOW   8'h3a
`define SARC_IDX_SLOT4_VHIGH  8'h3b
`define SARC_IDX_SLOT4_CUR    8'h3c
`define SARC_IDX_IRQ_STATUS   8'h60
`define SARC_IDX_IRQ_MASK     8'h61
`define SARC_IDX_VALID        8'h62
`define SARC_IDX_RESULT       8'h63

// ==========================================================
// Reset values
`define SARC_RST_SLOT2_VHIGH  8'h74
`define SARC_RST_SLOT2_VLOW   8'h66
`define SARC_RST_SLOT2_CUR    2'h1
`define SARC_RST_SLOT3_VHIGH  8'hd9
`define SARC_RST_SLOT3_VLOW   8'hbf
`define SARC_RST_SLOT3_CUR    2'h1
`define SARC_RST_SLOT4_VLOW   8'h00
`define SARC_RST_SLOT4_VHIGH  8'h00
`define SARC_RST_SLOT4_CUR    2'h0

// ==========================================================
// Forced results and field positions
`define SARC_VADC_GROUND      8'h00
`define SARC_VADC_OPEN        8'hff
`define SARC_CUR_NONE         2'h0
`define SARC_CUR_GROUND       2'h3
`define SARC_STAT_DONE_BIT    0
`define SARC_STAT_SLOT_LSB    1
`define SARC_RESULT_CUR_LSB   8

`endif

// file: verilog/sarc_pkg.sv
/*
  Types of the sideband accessory resistor classifier.
  Assumes: nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package sarc_pkg;

  // ==========================================================
  // Pullup current codes: 2uA, 8uA, 32uA, 128uA
  typedef enum logic [1:0] {
    SARC_CUR_2UA   = 2'h0,
    SARC_CUR_8UA   = 2'h1,
    SARC_CUR_32UA  = 2'h2,
    SARC_CUR_128UA = 2'h3
  } sarc_cur_t;

  // Outcome of one measurement
  typedef enum logic [1:0] {
    SARC_OUT_NORMAL = 2'h0,
    SARC_OUT_ABORT  = 2'h1,
    SARC_OUT_GROUND = 2'h2,
    SARC_OUT_OPEN   = 2'h3
  } sarc_outcome_t;

  typedef struct packed {
    sarc_outcome_t outcome;
    logic [7:0]    vadc;
    logic [1:0]    cur_code;
  } sarc_meas_t;

  typedef struct packed {
    logic [7:0] volt_low;
    logic [7:0] volt_high;
    logic [1:0] expected_current;
  } sarc_slot_cfg_t;

endpackage

`default_nettype wire

// file: verilog/sarc_slot_match.sv
/*
  One accessory slot comparator.
  Assumes: final voltage and pullup are already forced for abort, ground, open.
*/
`default_nettype none

module sarc_slot_match (
  input  wire sarc_pkg::sarc_slot_cfg_t cfg,
  input  wire logic [7:0]               vadc,
  input  wire logic [1:0]               cur_code,
  output logic                          match
);

  // ==========================================================
  // Inclusive range and exact current code
  always_comb begin
    match = (cur_code == cfg.expected_current) &&
            (vadc >= cfg.volt_low) && (vadc <= cfg.volt_high); // RQ11
  end

endmodule // sarc_slot_match

`default_nettype wire

// file: verilog/sarc_classifier.sv
/*
  Sideband accessory resistor classifier with APB register slave.
  Assumes: measurement front end gives one-cycle meas_done with final results,
  synchronous to clk_sys; APB master per the APB protocol.
*/
`include "sarc_regs.svh"
`default_nettype none

// How it works
// RQ1 - Slot 2 valid when pullup code matches and voltage lies in its range.
// RQ2 - Slot 3 valid when pullup code matches and voltage lies in its range.
// RQ3 - Slot 4 valid when pullup code matches and voltage lies in its range.
// RQ4 - Pullup codes 0..3 mean 2, 8, 32, 128 uA, same as measured code.
// RQ5 - Thresholds are eight bits compared directly to the eight-bit result.
// RQ6 - Slot 2 resets to low 0x66 and current code 0x1.
// RQ7 - Slot 3 resets to high 0xd9, low 0xbf, current code 0x1.
// RQ8 - Slot 4 resets to low 0x00, high 0x00, current code 0x0.
// RQ9 - Voltage forced 0x00 on abort or ground, 0xff on open.
// RQ10 - Pullup forced 0b00 on abort or open, 0b11 on ground.
// RQ11 - Range inclusive at both ends; flags updated at each completed measurement.
module sarc_classifier #(
  parameter int NUM_SLOTS = 3
) (
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 meas_done,
  input  wire sarc_pkg::sarc_meas_t meas,
  output logic      [NUM_SLOTS-1:0] slot_valid,
  output logic                      irq
);

  // ==========================================================
  // Storage
  sarc_pkg::sarc_slot_cfg_t cfg_ff [NUM_SLOTS];
  logic [NUM_SLOTS:0]       status_ff;
  logic [NUM_SLOTS:0]       mask_ff;
  logic [NUM_SLOTS-1:0]     valid_ff;
  logic [7:0]               last_vadc_ff;
  logic [1:0]               last_cur_ff;
  logic [31:0]              prdata_ff;
  logic                     pready_ff;
  logic                     pslverr_ff;
  logic                     irq_ff;

  logic [7:0]               fin_vadc;
  logic [1:0]               fin_cur;
  logic [NUM_SLOTS-1:0]     match;
  logic [NUM_SLOTS:0]       nxt_status;
  logic [NUM_SLOTS:0]       set_evt;
  logic [31:0]              nxt_prdata;
  logic                     hit;
  logic                     acc;
  logic                     wr_en;
  logic [9:0]               idx;

  // ==========================================================
  // Final result forcing
  always_comb begin
    fin_vadc = meas.vadc;
    fin_cur  = meas.cur_code;
    case (meas.outcome)
      sarc_pkg::SARC_OUT_ABORT: begin
        fin_vadc = `SARC_VADC_GROUND; // RQ9
        fin_cur  = `SARC_CUR_NONE; // RQ10
      end
      sarc_pkg::SARC_OUT_GROUND: begin
        fin_vadc = `SARC_VADC_GROUND; // RQ9
        fin_cur  = `SARC_CUR_GROUND; // RQ10
      end
      sarc_pkg::SARC_OUT_OPEN: begin
        fin_vadc = `SARC_VADC_OPEN; // RQ9
        fin_cur  = `SARC_CUR_NONE; // RQ10
      end
      default: begin
        fin_vadc = meas.vadc;
        fin_cur  = meas.cur_code;
      end
    endcase
  end

  // ==========================================================
  // Slot comparators
  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
      sarc_slot_match u_match (
        .cfg    (cfg_ff[g]),
        .vadc   (fin_vadc),
        .cur_code (fin_cur),
        .match  (match[g])
      ); // RQ1 RQ2 RQ3 RQ4 RQ5
    end
  endgenerate

  // ==========================================================
  // Valid flags, re-evaluated on each completed measurement
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      valid_ff     <= '0;
      last_vadc_ff <= 8'h00;
      last_cur_ff  <= 2'h0;
    end else if (meas_done) begin
      valid_ff     <= match; // RQ11
      last_vadc_ff <= fin_vadc;
      last_cur_ff  <= fin_cur;
    end
  end

  // ==========================================================
  // APB decode
  always_comb begin
    acc   = psel && penable;
    idx   = paddr[11:2];
    wr_en = acc && pready_ff && pwrite && hit && !pslverr_ff;
  end

  always_comb begin
    hit        = 1'b1;
    nxt_prdata = 32'h0000_0000;
    case (idx)
      10'(`SARC_IDX_SLOT2_VHIGH): nxt_prdata[7:0] = cfg_ff[0].volt_high;
      10'(`SARC_IDX_SLOT2_VLOW):  nxt_prdata[7:0] = cfg_ff[0].volt_low;
      10'(`SARC_IDX_SLOT2_CUR):   nxt_prdata[1:0] = cfg_ff[0].expected_current;
      10'(`SARC_IDX_SLOT3_VHIGH): nxt_prdata[7:0] = cfg_ff[1].volt_high;
      10'(`SARC_IDX_SLOT3_VLOW):  nxt_prdata[7:0] = cfg_ff[1].volt_low;
      10'(`SARC_IDX_SLOT3_CUR):   nxt_prdata[1:0] = cfg_ff[1].expected_current;
      10'(`SARC_IDX_SLOT4_VLOW):  nxt_prdata[7:0] = cfg_ff[2].volt_low;
      10'(`SARC_IDX_SLOT4_VHIGH): nxt_prdata[7:0] = cfg_ff[2].volt_high;
      10'(`SARC_IDX_SLOT4_CUR):   nxt_prdata[1:0] = cfg_ff[2].expected_current;
      10'(`SARC_IDX_IRQ_STATUS):  nxt_prdata[NUM_SLOTS:0] = status_ff;
      10'(`SARC_IDX_IRQ_MASK):    nxt_prdata[NUM_SLOTS:0] = mask_ff;
      10'(`SARC_IDX_VALID):       nxt_prdata[NUM_SLOTS-1:0] = valid_ff;
      10'(`SARC_IDX_RESULT): begin
        nxt_prdata[7:0] = last_vadc_ff;
        nxt_prdata[`SARC_RESULT_CUR_LSB +: 2] = last_cur_ff;
      end
      default: hit = 1'b0;
    endcase
  end

  // ==========================================================
  // APB answer: one wait state, error on unmapped index
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else if (acc && !pready_ff) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= !hit;
      prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Slot configuration registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_ff[0] <= '{`SARC_RST_SLOT2_VLOW, `SARC_RST_SLOT2_VHIGH,
                     `SARC_RST_SLOT2_CUR}; // RQ6
      cfg_ff[1] <= '{`SARC_RST_SLOT3_VLOW, `SARC_RST_SLOT3_VHIGH,
                     `SARC_RST_SLOT3_CUR}; // RQ7
      cfg_ff[2] <= '{`SARC_RST_SLOT4_VLOW, `SARC_RST_SLOT4_VHIGH,
                     `SARC_RST_SLOT4_CUR}; // RQ8
    end else if (wr_en) begin
      case (idx)
        10'(`SARC_IDX_SLOT2_VHIGH): cfg_ff[0].volt_high        <= pwdata[7:0];
        10'(`SARC_IDX_SLOT2_VLOW):  cfg_ff[0].volt_low         <= pwdata[7:0];
        10'(`SARC_IDX_SLOT2_CUR):   cfg_ff[0].expected_current <= pwdata[1:0];
        10'(`SARC_IDX_SLOT3_VHIGH): cfg_ff[1].volt_high        <= pwdata[7:0];
        10'(`SARC_IDX_SLOT3_VLOW):  cfg_ff[1].volt_low         <= pwdata[7:0];
        10'(`SARC_IDX_SLOT3_CUR):   cfg_ff[1].expected_current <= pwdata[1:0];
        10'(`SARC_IDX_SLOT4_VLOW):  cfg_ff[2].volt_low         <= pwdata[7:0];
        10'(`SARC_IDX_SLOT4_VHIGH): cfg_ff[2].volt_high        <= pwdata[7:0];
        10'(`SARC_IDX_SLOT4_CUR):   cfg_ff[2].expected_current <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Interrupt status, mask and output
  always_comb begin
    set_evt = '0;
    set_evt[`SARC_STAT_DONE_BIT] = meas_done;
    set_evt[`SARC_STAT_SLOT_LSB +: NUM_SLOTS] = {NUM_SLOTS{meas_done}} & match & ~valid_ff;
    nxt_status = status_ff;
    if (wr_en && idx == 10'(`SARC_IDX_IRQ_STATUS)) begin
      nxt_status = status_ff & ~pwdata[NUM_SLOTS:0];
    end
    nxt_status = nxt_status | set_evt;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_ff <= '0;
      mask_ff   <= '0;
      irq_ff    <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      if (wr_en && idx == 10'(`SARC_IDX_IRQ_MASK)) begin
        mask_ff <= pwdata[NUM_SLOTS:0];
      end
      irq_ff <= |(nxt_status & mask_ff);
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    prdata     = prdata_ff;
    pready     = pready_ff;
    pslverr    = pslverr_ff;
    slot_valid = valid_ff;
    irq        = irq_ff;
  end

endmodule // sarc_classifier

`default_nettype wire

// file: bench/sarc_classifier_assertions.sv
/*
  Checker for the classifier top ports.
  Assumes: bound into every sarc_classifier instance.
*/
`default_nettype none

module sarc_classifier_checker #(
  parameter int NUM_SLOTS = 3
) (
  input wire logic                 clk_sys,
  input wire logic                 srst,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 meas_done,
  input wire sarc_pkg::sarc_meas_t meas,
  input wire logic [NUM_SLOTS-1:0] slot_valid,
  input wire logic                 irq
);
  // ==========================================================
  // Helpers
  logic [9:0] idx;
  logic       unmapped;
  logic [9:0] res_ff;
  assign idx = paddr[11:2];
  assign unmapped = !(idx inside {[10'h34:10'h3c], [10'h60:10'h63]});
  always_ff @(posedge clk_sys) begin
    if (srst) res_ff <= '0;
    else if (meas_done) begin
      case (meas.outcome)
        sarc_pkg::SARC_OUT_ABORT:  res_ff <= 10'h000;
        sarc_pkg::SARC_OUT_GROUND: res_ff <= 10'h003;
        sarc_pkg::SARC_OUT_OPEN:   res_ff <= 10'h3fc;
        default:                   res_ff <= {meas.vadc, meas.cur_code};
      endcase
    end
  end

  // ==========================================================
  // Properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_once: assert property (pready |=> !pready) else $error("pready too long");
  a_err_decode: assert property (pready |-> pslverr == unmapped) else $error("bad decode");
  a_err_nodata: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("data on error");
  a_valid_hold: assert property (!meas_done |=> $stable(slot_valid))
    else $error("valid moved");
  a_valid_read: assert property (pready && !pwrite && idx == 10'h62 && $stable(slot_valid)
    |-> prdata == 32'(slot_valid)) else $error("valid read");
  a_result_read: assert property (pready && !pwrite && idx == 10'h63 && !$past(meas_done)
    |-> prdata == {22'h0, res_ff[1:0], res_ff[9:2]}) else $error("result");
  a_irq_cause: assert property ($rose(irq) |-> $past(meas_done) || $past(pwrite && pready)
    || $past(pwrite && pready, 2)) else $error("irq cause");
  c_err: cover property (pready && pslverr);
  c_ground: cover property (meas_done && meas.outcome == sarc_pkg::SARC_OUT_GROUND);
  c_irq: cover property ($rose(irq));
endmodule // sarc_classifier_checker

bind sarc_classifier sarc_classifier_checker #(.NUM_SLOTS(NUM_SLOTS)) u_sarc_classifier_checker (
  .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .meas_done(meas_done), .meas(meas), .slot_valid(slot_valid), .irq(irq));

`default_nettype wire

// file: bench/sarc_front_model.sv
/*
  Measurement front end model: fires one result after a chosen lag.
  Assumes: go is a one-cycle request from the bench.
*/
`default_nettype none

module sarc_front_model (
  input  wire logic                 clk_sys,
  input  wire logic                 go,
  input  wire logic [1:0]           lag,
  input  wire sarc_pkg::sarc_meas_t req,
  output logic                      meas_done,
  output sarc_pkg::sarc_meas_t      meas
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0]           cnt_ff = '0;
  sarc_pkg::sarc_meas_t hold_ff = '0;
  initial meas_done = 1'b0;
  initial meas = '0;
  // Result lines scramble outside the done cycle
  always @(posedge clk_sys) begin
    meas_done <= (cnt_ff == 3'h1);
    meas <= (cnt_ff == 3'h1) ? hold_ff : ~meas;
    if (go) begin
      cnt_ff <= {1'b0, lag} + 3'h1;
      hold_ff <= req;
    end else if (cnt_ff != 3'h0) cnt_ff <= cnt_ff - 3'h1;
  end
endmodule // sarc_front_model

`default_nettype wire

// file: bench/tb_top.sv
/*
  Self-checking bench of the classifier.
  Assumes: APB slave with one wait state; front end model beside it.
*/
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, go = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, meas_done, irq;
  logic [1:0]  lag = '0;
  logic [2:0]  slot_valid;
  sarc_pkg::sarc_meas_t req = '0, meas;
  logic [7:0]  cf[9] = '{8'h74, 8'h66, 8'h01, 8'hd9, 8'hbf, 8'h01, 8'h00, 8'h00, 8'h00};
  logic [7:0]  bv[4] = '{8'h3f, 8'h40, 8'h50, 8'h51};
  int          fails = 0, n_compared = 0;
  always #12.5 clk_sys = ~clk_sys;

  sarc_classifier #(.NUM_SLOTS(3)) u_sarc_classifier (.clk_sys(clk_sys), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas_done(meas_done),
    .meas(meas), .slot_valid(slot_valid), .irq(irq));
  sarc_front_model u_sarc_front_model (.clk_sys(clk_sys), .go(go), .lag(lag), .req(req),
    .meas_done(meas_done), .meas(meas));

  // ==========================================================
  // Tasks and reference
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] ix, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel <= 1; pwrite <= w; paddr <= {ix, 2'b00}; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata; e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic rd(input logic [9:0] ix, input logic [31:0] exp);
    logic [31:0] r; logic e;
    apb(0, ix, 0, r, e);
    chk("rdata", exp, r);
  endtask
  task automatic wcf(input int k, input logic [7:0] d);
    logic [31:0] r; logic e;
    cf[k] = (k % 3 == 2) ? {6'h0, d[1:0]} : d;
    apb(1, 10'(10'h34 + k), {24'h0, d}, r, e);
    rd(10'(10'h34 + k), {24'h0, cf[k]});
  endtask
  function automatic logic hit(input logic [7:0] lo, hi, cu, v, input logic [1:0] i);
    return cu[1:0] == i && v >= lo && v <= hi;
  endfunction
  function automatic logic [2:0] expv(input sarc_pkg::sarc_meas_t m);
    logic [9:0] f;
    f = {m.vadc, m.cur_code};
    if (m.outcome == sarc_pkg::SARC_OUT_ABORT) f = 10'h000;
    if (m.outcome == sarc_pkg::SARC_OUT_GROUND) f = 10'h003;
    if (m.outcome == sarc_pkg::SARC_OUT_OPEN) f = 10'h3fc;
    return {hit(cf[6], cf[7], cf[8], f[9:2], f[1:0]), hit(cf[4], cf[3], cf[5], f[9:2], f[1:0]),
            hit(cf[1], cf[0], cf[2], f[9:2], f[1:0])};
  endfunction
  task automatic ms(input sarc_pkg::sarc_meas_t m);
    req <= m; go <= 1; lag <= 2'($urandom);
    @(posedge clk_sys);
    go <= 0;
    do @(posedge clk_sys); while (meas_done !== 1'b1);
    @(posedge clk_sys);
    chk("slot_valid", {29'h0, expv(m)}, {29'h0, slot_valid});
  endtask
  task test_done();
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // Sequence
  initial begin
    sarc_pkg::sarc_meas_t m; logic [31:0] r; logic e;
    void'($urandom(71804));
    repeat (6) @(posedge clk_sys);
    srst <= 0;
    for (int k = 0; k < 9; k++) rd(10'(10'h34 + k), {24'h0, cf[k]});
    apb(0, 10'h40, 32'h0, r, e);
    chk("unmapped_rd", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, r);
    apb(1, 10'h3d, 32'hff, r, e);
    chk("unmapped_wr", 32'h1, {31'h0, e});
    for (int c = 0; c < 4; c++) begin
      wcf(4, 8'h40); wcf(3, 8'h50); wcf(5, 8'(c));
      for (int j = 0; j < 4; j++) ms({sarc_pkg::SARC_OUT_NORMAL, bv[j], 2'(c)});
    end
    wcf(2, 8'h03); wcf(1, 8'h00); wcf(7, 8'hff);
    for (int o = 0; o < 4; o++) begin
      m = 12'($urandom);
      m.outcome = sarc_pkg::sarc_outcome_t'(o);
      ms(m);
    end
    apb(1, 10'h60, 32'hf, r, e);
    apb(1, 10'h61, 32'h1, r, e);
    ms(m);
    chk("irq_set", 32'h1, {31'h0, irq});
    apb(0, 10'h60, 32'h0, r, e);
    chk("status_done", 32'h1, {31'h0, r[0]});
    apb(1, 10'h60, 32'hf, r, e);
    @(posedge clk_sys);
    chk("irq_clear", 32'h0, {31'h0, irq});
    apb(1, 10'h61, 32'h0, r, e);
    ms(m);
    chk("irq_masked", 32'h0, {31'h0, irq});
    repeat (60) begin
      wcf($urandom_range(8), 8'($urandom));
      m = 12'($urandom);
      ms(m);
    end
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    test_done();
  end
endmodule // tb_top

`default_nettype wire
